// file: src/frame_pace_gen.sv
// Purpose: Internal frame-start generator with programmable period
// Assumes: Periods are counted in pclk cycles
// Notes:   Period floors at the minimum allowed period
`include "fst_map.svh"
`timescale 1ns/10ps
module frame_pace_gen (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic clk_en,
   // Pace link
   pace_if.gen       pace
);
   logic [31:0] count;
   logic [31:0] eff_period;

   // ------------------------------------------------------------
   // Effective period
   // ------------------------------------------------------------
   always_comb begin
      if (!pace.pace_en) begin
         eff_period = pace.min_period;
      end else if (pace.period < pace.min_period) begin
         eff_period = pace.min_period;
      end else begin
         eff_period = pace.period;
      end
      if (eff_period == `ZERO32) begin
         eff_period = `ONE32;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count     <= `ZERO32;
         pace.tick <= 1'b0;
      end else if (clk_en) begin
         pace.tick <= 1'b0;
         if (!pace.run) begin
            count <= `ZERO32;
         end else if (count == `ZERO32) begin
            pace.tick <= 1'b1;
            count     <= eff_period - `ONE32;
         end else begin
            count <= count - `ONE32;
         end
      end
   end
endmodule

// file: src/frame_start_ctrl.sv
// Purpose: Frame-start trigger control with APB register access
// Assumes: One clock pclk at 100 MHz; line 1 is asynchronous
// Notes:   Exposure counted in pclk cycles
//
// Overview of operation
// - In waiting status, each accepted frame-start event begins one frame.
// - External select off: all frame-start events created internally.
// - Single-frame kind, internal: exactly one event per run-begin.
// - Continuous kind, internal: events from run-begin until run-end.
// - Pace disabled: events at maximum allowed rate.
// - Pace enabled and below maximum: events at programmed rate.
// - Pace enabled above maximum: events limited to maximum rate.
// - Events act only in waiting status, from any origin.
// - External select off: exposure from fixed exposure length.
// - External select on: each frame triggered from selected origin.
// - Line origin: rising or falling edge per polarity select.
// - Reset selects input line 1 as origin.
// - Software origin: exposure from exposure time setting.
// - Line origin: exposure from setting or trigger pulse width.
// - Control comes up in legacy mode, not standard mode.
// - Events outside waiting status are discarded.
// - Leave waiting on exposure; when ready, return to waiting if running or external, else go idle.
`include "fst_map.svh"
`timescale 1ns/10ps
module frame_start_ctrl (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Trigger pin
   input  wire logic        line1,
   // Acquisition outputs
   output logic             frame_start,
   output logic             exposing,
   output logic             waiting
);
   pace_if pace ();

   logic [31:0]          ctrl;
   logic [31:0]          period;
   logic [31:0]          min_period;
   logic [31:0]          exposure;
   logic [31:0]          frame_count;
   logic [31:0]          exp_cnt;
   logic [31:0]          rec_cnt;
   logic                 drop;
   logic                 line_s1;
   logic                 line_s2;
   logic                 line_d;
   logic                 run;
   logic                 armed;
   logic                 wr;
   logic                 rd;
   logic                 cmd_begin;
   logic                 cmd_end;
   logic                 cmd_soft;
   logic                 cmd_acq;
   logic                 line_edge;
   logic                 line_active;
   logic                 event_in;
   logic                 accept;
   fst_pkg::acq_state_t  state;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == `OFF_CTRL) || (a == `OFF_CMD) || (a == `OFF_PERIOD) ||
               (a == `OFF_MINPER) || (a == `OFF_EXPOSURE) || (a == `OFF_STATUS) ||
               (a == `OFF_COUNT);
   endfunction

   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !mapped(paddr);
   assign wr        = psel && penable && pwrite && clk_en && mapped(paddr);
   assign rd        = psel && !penable && !pwrite;
   assign cmd_begin = wr && (paddr == `OFF_CMD) && pwdata[`CMD_RUN_BEGIN];
   assign cmd_end   = wr && (paddr == `OFF_CMD) && pwdata[`CMD_RUN_END];
   assign cmd_soft  = wr && (paddr == `OFF_CMD) && pwdata[`CMD_SOFT_TRIG];
   assign cmd_acq   = wr && (paddr == `OFF_CMD) && pwdata[`CMD_ACQ_TRIG];

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl       <= `CTRL_RESET;
         period     <= `PERIOD_RESET;
         min_period <= `MINPER_RESET;
         exposure   <= `EXPOSURE_RESET;
      end else if (wr) begin
         if (paddr == `OFF_CTRL) begin
            ctrl <= pwdata;
         end else if (paddr == `OFF_PERIOD) begin
            period <= pwdata;
         end else if (paddr == `OFF_MINPER) begin
            min_period <= pwdata;
         end else if (paddr == `OFF_EXPOSURE) begin
            exposure <= pwdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `ZERO32;
      end else if (clk_en && rd) begin
         if (paddr == `OFF_CTRL) begin
            prdata <= ctrl;
         end else if (paddr == `OFF_PERIOD) begin
            prdata <= period;
         end else if (paddr == `OFF_MINPER) begin
            prdata <= min_period;
         end else if (paddr == `OFF_EXPOSURE) begin
            prdata <= exposure;
         end else if (paddr == `OFF_STATUS) begin
            prdata <= {27'h000_0000, drop, armed, run, exposing, waiting};
         end else if (paddr == `OFF_COUNT) begin
            prdata <= frame_count;
         end else begin
            prdata <= `ZERO32;
         end
      end
   end

   // ------------------------------------------------------------
   // Line 1 synchroniser and edge detect
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_s1 <= 1'b0;
         line_s2 <= 1'b0;
         line_d  <= 1'b0;
      end else if (clk_en) begin
         line_s1 <= line1;
         line_s2 <= line_s1;
         line_d  <= line_s2;
      end
   end

   assign line_active = ctrl[`CTRL_FALL] ? !line_s2 : line_s2;
   assign line_edge   = ctrl[`CTRL_FALL] ? (line_d && !line_s2)
                                         : (!line_d && line_s2);

   // ------------------------------------------------------------
   // Event selection
   // ------------------------------------------------------------
   always_comb begin
      if (!ctrl[`CTRL_EXT]) begin
         event_in = pace.tick;
      end else if (ctrl[`CTRL_ORIGIN]) begin
         event_in = line_edge;
      end else begin
         event_in = cmd_soft;
      end
   end

   // Events only count in waiting status and in standard mode
   assign accept = ctrl[`CTRL_STD] && (state == fst_pkg::ST_WAIT) && event_in;
   assign waiting  = (state == fst_pkg::ST_WAIT);
   assign exposing = (state == fst_pkg::ST_EXPOSE);

   // ------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run <= 1'b0;
      end else if (clk_en) begin
         if (cmd_end || !ctrl[`CTRL_STD]) begin
            run <= 1'b0;
         end else if (cmd_begin) begin
            run <= 1'b1;
         end else if (accept && !ctrl[`CTRL_CONT]) begin
            run <= 1'b0;
         end
      end
   end

   // Pacing keeps counting through exposures so the period holds
   assign pace.run        = run && !ctrl[`CTRL_EXT] && (waiting || exposing);
   assign pace.pace_en    = ctrl[`CTRL_PACE_EN];
   assign pace.period     = period;
   assign pace.min_period = min_period;

   frame_pace_gen u_gen (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .pace    (pace)
   );

   // ------------------------------------------------------------
   // Acquisition state
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= fst_pkg::ST_IDLE;
         armed   <= 1'b0;
         exp_cnt <= `ZERO32;
         rec_cnt <= `ZERO32;
      end else if (clk_en) begin
         armed <= 1'b0;
         case (state)
            fst_pkg::ST_IDLE: begin
               if (cmd_begin && ctrl[`CTRL_STD]) begin
                  state <= ctrl[`CTRL_ASTRIG_EN] ? fst_pkg::ST_ARM : fst_pkg::ST_WAIT;
               end
            end
            fst_pkg::ST_ARM: begin
               armed <= 1'b1;
               if (cmd_end) begin
                  state <= fst_pkg::ST_IDLE;
               end else if (cmd_acq) begin
                  state <= fst_pkg::ST_WAIT;
               end
            end
            fst_pkg::ST_WAIT: begin
               if (accept) begin
                  state   <= fst_pkg::ST_EXPOSE;
                  exp_cnt <= exposure;
                  rec_cnt <= `RECOVER_CYCLES;
               end else if (cmd_end || !run && !ctrl[`CTRL_EXT]) begin
                  state <= fst_pkg::ST_IDLE;
               end
            end
            fst_pkg::ST_EXPOSE: begin
               if (ctrl[`CTRL_EXT] && ctrl[`CTRL_ORIGIN] && ctrl[`CTRL_WIDTH_EXP]) begin
                  if (!line_active) begin
                     exp_cnt <= `ZERO32;
                  end
               end else if (exp_cnt != `ZERO32) begin
                  exp_cnt <= exp_cnt - `ONE32;
               end
               if (exp_cnt == `ZERO32 || (ctrl[`CTRL_WIDTH_EXP] && ctrl[`CTRL_EXT]
                   && ctrl[`CTRL_ORIGIN] && !line_active)) begin
                  if (rec_cnt != `ZERO32) begin
                     rec_cnt <= rec_cnt - `ONE32;
                  end else if (run || ctrl[`CTRL_EXT]) begin
                     state <= fst_pkg::ST_WAIT;
                  end else begin
                     state <= fst_pkg::ST_IDLE;
                  end
               end
            end
            default: state <= fst_pkg::ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Frame pulse, counter and overtrigger flag
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_start <= 1'b0;
         frame_count <= `ZERO32;
         drop        <= 1'b0;
      end else if (clk_en) begin
         frame_start <= accept;
         if (accept) begin
            frame_count <= frame_count + `ONE32;
         end
         if (event_in && !accept) begin
            drop <= 1'b1;
         end else if (wr && paddr == `OFF_STATUS) begin
            drop <= 1'b0;
         end
      end
   end
endmodule

// file: src/fst_map.svh
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef FST_MAP_SVH
`define FST_MAP_SVH
// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define OFF_CTRL        12'h000
`define OFF_CMD         12'h004
`define OFF_PERIOD      12'h008
`define OFF_MINPER      12'h00C
`define OFF_EXPOSURE    12'h010
`define OFF_STATUS      12'h014
`define OFF_COUNT       12'h018
// ---------------------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------------------
`define CTRL_EXT        0
`define CTRL_ORIGIN     1
`define CTRL_FALL       2
`define CTRL_CONT       3
`define CTRL_PACE_EN    4
`define CTRL_WIDTH_EXP  5
`define CTRL_STD        6
`define CTRL_ASTRIG_EN  7
`define CTRL_RESET      32'h0000_0002
// ---------------------------------------------------------------------------
// Command fields (write one to act)
// ---------------------------------------------------------------------------
`define CMD_RUN_BEGIN   0
`define CMD_RUN_END     1
`define CMD_SOFT_TRIG   2
`define CMD_ACQ_TRIG    3
// ---------------------------------------------------------------------------
// Status fields
// ---------------------------------------------------------------------------
`define STAT_WAIT       0
`define STAT_BUSY       1
`define STAT_RUN        2
`define STAT_ARMWAIT    3
`define STAT_DROP       4
// ---------------------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------------------
`define PERIOD_RESET    32'h0000_0064
`define MINPER_RESET    32'h0000_0032
`define EXPOSURE_RESET  32'h0000_001E
`define RECOVER_CYCLES  32'h0000_0004
`define ZERO32          32'h0000_0000
`define ONE32           32'h0000_0001
`endif

// file: src/fst_pkg.sv
// Purpose: Types shared by the frame-start trigger design
// Assumes: Nothing beyond the map header
// Notes:   Types only
package fst_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARM,
      ST_WAIT,
      ST_EXPOSE
   } acq_state_t;
endpackage

// file: src/pace_if.sv
// Purpose: Carries pace settings and tick between generator and controller
// Assumes: One clock domain
// Notes:   None
`timescale 1ns/10ps
interface pace_if;
   logic        run;
   logic        pace_en;
   logic [31:0] period;
   logic [31:0] min_period;
   logic        tick;
   modport ctrl (output run, output pace_en, output period, output min_period, input tick);
   modport gen  (input run, input pace_en, input period, input min_period, output tick);
endinterface

// file: tb/frame_start_ctrl_asserts.sv
// Purpose: Port-level checks for the frame-start trigger block
// Assumes: Control and exposure shadows follow completed APB writes
// Notes:   Bound to frame_start_ctrl at the foot of this file
`include "fst_map.svh"
`timescale 1ns/10ps
module frame_start_ctrl_asserts (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        clk_en,
   // APB slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Trigger and acquisition
   input wire logic        line1,
   input wire logic        frame_start,
   input wire logic        exposing,
   input wire logic        waiting
);
   logic [31:0] ctl;
   logic [31:0] expo;
   logic [31:0] ecnt;
   logic [1:0]  scnt;
   logic        wr;
   logic        cmd;
   // ------------------------------------------------------------------
   // Shadows
   // ------------------------------------------------------------------
   assign wr = psel && penable && pwrite && pready && clk_en;
   assign cmd = wr && paddr == `OFF_CMD;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl <= 32'h0000_0002;
         expo <= 32'h0000_001E;
      end else if (wr && paddr == `OFF_CTRL) begin
         ctl <= pwdata;
      end else if (wr && paddr == `OFF_EXPOSURE) begin
         expo <= pwdata;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ecnt <= 32'h0000_0000;
      end else begin
         ecnt <= exposing ? ecnt + 32'h0000_0001 : 32'h0000_0000;
      end
   end
   // Frames seen since the last run-begin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scnt <= 2'h0;
      end else if (cmd && pwdata[0]) begin
         scnt <= 2'h0;
      end else if (frame_start && scnt != 2'h3) begin
         scnt <= scnt + 2'h1;
      end
   end
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_line_edge;
      ctl[0] && ctl[1] && ctl[6] && waiting && (ctl[2] ? $fell(line1) : $rose(line1))
      ##1 waiting [*2];
   endsequence
   sequence s_soft;
      cmd && pwdata[2] && ctl[0] && !ctl[1] && ctl[6] && !ctl[7] && waiting;
   endsequence
   sequence s_run_end;
      cmd && pwdata[1] && !pwdata[0] && !ctl[0];
   endsequence
   property p_fs_pulse; frame_start |=> !frame_start; endproperty
   a_fs_pulse: assert property (p_fs_pulse) else $error("frame_start too wide");
   property p_fs_wait; frame_start |-> $past(waiting); endproperty
   a_fs_wait: assert property (p_fs_wait) else $error("frame outside wait");
   property p_fs_expose; frame_start |-> ##[0:1] (exposing && !waiting); endproperty
   a_fs_expose: assert property (p_fs_expose) else $error("no exposure");
   property p_exp_len;
      $fell(exposing) && !ctl[5] |-> ecnt == expo + `RECOVER_CYCLES + 32'h0000_0001;
   endproperty
   a_exp_len: assert property (p_exp_len) else $error("exposure length wrong");
   property p_legacy; !ctl[6] && !$past(ctl[6]) |-> !frame_start; endproperty
   a_legacy: assert property (p_legacy) else $error("frame in legacy mode");
   property p_single; frame_start && !ctl[0] && !ctl[3] |-> scnt == 2'h0; endproperty
   a_single: assert property (p_single) else $error("extra single frame");
   property p_soft; s_soft |-> ##[1:3] frame_start; endproperty
   a_soft: assert property (p_soft) else $error("software trigger lost");
   property p_line; s_line_edge |-> ##[0:3] frame_start; endproperty
   a_line: assert property (p_line) else $error("line edge lost");
   property p_run_end; s_run_end |-> ##4 !frame_start [*8]; endproperty
   a_run_end: assert property (p_run_end) else $error("frame after run end");
endmodule
bind frame_start_ctrl frame_start_ctrl_asserts u_chk (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .line1(line1), .frame_start(frame_start), .exposing(exposing),
   .waiting(waiting)
);

// file: tb/frame_start_ctrl_tb_top.sv
// Purpose: Self-checking bench for the frame-start trigger block
// Assumes: APB slave answers when pready is seen high
// Notes:   Partner model drives line 1
`include "fst_map.svh"
`timescale 1ns/10ps
module frame_start_ctrl_tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        line1;
   logic        frame_start;
   logic        exposing;
   logic        waiting;
   logic [31:0] rd;
   logic        err;
   logic [31:0] per [3] = '{32'h0000_0064, 32'h0000_0064, 32'h0000_0014};
   logic [31:0] ctl [3] = '{32'h0000_0048, 32'h0000_0058, 32'h0000_0058};
   logic [31:0] gap [3] = '{32'h0000_0032, 32'h0000_0064, 32'h0000_0032};
   int          n_fail = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          n_fs = 0;
   int          last_fs = 0;
   int          ival = 0;
   int          ecnt = 0;
   int          elen = 0;
   int          base = 0;
   always #5 pclk = ~pclk;
   frame_start_ctrl u_dut (
      .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .line1(line1), .frame_start(frame_start), .exposing(exposing),
      .waiting(waiting)
   );
   trig_src u_src (.pclk(pclk), .line1(line1));
   // Frame, interval and exposure monitor plus hang limit
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (frame_start === 1'b1) begin
         n_fs <= n_fs + 1;
         ival <= cyc - last_fs;
         last_fs <= cyc;
      end
      ecnt <= (exposing === 1'b1) ? ecnt + 1 : 0;
      if (exposing !== 1'b1 && ecnt != 0) elen <= ecnt;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end
   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      check(what, rd, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic frames(input string what, input int e);
      check(what, 32'(n_fs - base), 32'(e));
   endtask
   task automatic conclude();
      $display("Counts: %0d checks, %0d mismatches", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("ctrl reset", `OFF_CTRL, 32'h0000_0002);
      rdchk("status reset", `OFF_STATUS, 32'h0000_0000);
      rdchk("exposure reset", `OFF_EXPOSURE, 32'h0000_001E);
      rdchk("unmapped", 12'h020, 32'h0000_0000);
      check("slverr", {31'h0000_0000, err}, 32'h0000_0001);
      base = n_fs;
      wr(`OFF_CMD, 32'h0000_0001);
      idle(200);
      frames("legacy frames", 0);
      wr(`OFF_CMD, 32'h0000_0002);
      $display("Test reset done");
      wr(`OFF_CTRL, 32'h0000_0040);
      base = n_fs;
      wr(`OFF_CMD, 32'h0000_0001);
      idle(300);
      frames("single", 1);
      check("timed exposure", 32'(elen), `EXPOSURE_RESET + `RECOVER_CYCLES + 32'h0000_0001);
      rdchk("count", `OFF_COUNT, 32'h0000_0001);
      $display("Test single done");
      for (int i = 0; i < 3; i++) begin
         wr(`OFF_PERIOD, per[i]);
         wr(`OFF_CTRL, ctl[i]);
         wr(`OFF_CMD, 32'h0000_0001);
         idle(400);
         check("interval", 32'(ival), gap[i]);
         wr(`OFF_CMD, 32'h0000_0002);
         idle(60);
         base = n_fs;
         idle(200);
         frames("after run end", 0);
      end
      $display("Test pace done");
      wr(`OFF_CTRL, 32'h0000_0041);
      wr(`OFF_CMD, 32'h0000_0001);
      base = n_fs;
      wr(`OFF_CMD, 32'h0000_0004);
      idle(8);
      wr(`OFF_CMD, 32'h0000_0004);
      idle(80);
      frames("soft", 1);
      check("soft exposure", 32'(elen), `EXPOSURE_RESET + `RECOVER_CYCLES + 32'h0000_0001);
      check("rewait", {31'h0000_0000, waiting}, 32'h0000_0001);
      apb(1'b0, `OFF_STATUS, 32'h0000_0000);
      check("dropped", rd & 32'h0000_0010, 32'h0000_0010);
      wr(`OFF_STATUS, 32'h0000_0000);
      apb(1'b0, `OFF_STATUS, 32'h0000_0000);
      check("drop clear", rd & 32'h0000_0010, 32'h0000_0000);
      wr(`OFF_CMD, 32'h0000_0004);
      idle(50);
      frames("soft again", 2);
      wr(`OFF_CMD, 32'h0000_0002);
      wr(`OFF_CTRL, 32'h0000_00C1);
      wr(`OFF_CMD, 32'h0000_0001);
      base = n_fs;
      wr(`OFF_CMD, 32'h0000_0004);
      idle(50);
      frames("unarmed", 0);
      wr(`OFF_CMD, 32'h0000_0008);
      wr(`OFF_CMD, 32'h0000_0004);
      idle(50);
      frames("armed", 1);
      wr(`OFF_CMD, 32'h0000_0002);
      $display("Test software done");
      for (int f = 0; f < 2; f++) begin
         u_src.set_idle(f == 1);
         idle(10);
         wr(`OFF_CTRL, (f == 1) ? 32'h0000_0047 : 32'h0000_0043);
         wr(`OFF_CMD, 32'h0000_0001);
         base = n_fs;
         repeat (2) begin
            u_src.pulse(6);
            idle(60);
         end
         frames("line edges", 2);
         wr(`OFF_CMD, 32'h0000_0002);
      end
      u_src.set_idle(1'b0);
      idle(10);
      wr(`OFF_CTRL, 32'h0000_0063);
      wr(`OFF_CMD, 32'h0000_0001);
      u_src.pulse(6);
      idle(60);
      check("width exposure", 32'(elen), `RECOVER_CYCLES + 32'h0000_0006);
      wr(`OFF_CMD, 32'h0000_0002);
      $display("Test line done");
      conclude();
   end
endmodule

// file: tb/trig_src.sv
// Purpose: External trigger source on input line 1
// Assumes: Bench requests one pulse per frame, spaced beyond a frame
// Notes:   Line is always driven, resting at the chosen idle level
`timescale 1ns/10ps
module trig_src (
   // Clock
   input  wire logic pclk,
   // Trigger pin
   output logic      line1
);
   logic idle_lvl = 1'b0;
   initial line1 = 1'b0;
   task automatic set_idle(input logic lvl);
      @(posedge pclk);
      idle_lvl = lvl;
      line1 <= lvl;
   endtask
   // One active pulse per requested frame
   task automatic pulse(input int hold);
      @(posedge pclk);
      line1 <= ~idle_lvl;
      repeat (hold) @(posedge pclk);
      line1 <= idle_lvl;
   endtask
endmodule
